// file: src/oblt_map.svh
// Purpose: offsets, field positions, reset values and counts of the option loader
// Assumes: word-indexed APB map, byte address is four times the index
// Notes:   definitions only
`ifndef OBLT_MAP_SVH
`define OBLT_MAP_SVH

// flash addresses fetched at reset, and the last fetch index
`define OBLT_FA_OPT_MOTOR    8'h01
`define OBLT_FA_OPT_RSVD     8'h02
`define OBLT_FA_OPT_BUS      8'h03
`define OBLT_FA_INFO_TRIM1   8'h21
`define OBLT_FA_INFO_TRIM2   8'h22
`define OBLT_FETCH_LAST      3'h4

// register indices as printed; decode uses the low index byte
`define OBLT_IDX_TRIM1       32'h0FFF_FF25
`define OBLT_IDX_TRIM2       32'hFFFF_FF26
`define OBLT_IDX_INFO1       32'h0000_0021
`define OBLT_IDX_INFO2       32'h0000_0022
`define OBLT_IDX_STATUS      32'h0000_0030
`define OBLT_IDX_BITS        8

// option byte fields and the status done bit
`define OBLT_BIT_MOTOR_EN    2
`define OBLT_BIT_HIGH_OFF    1
`define OBLT_BIT_LOW_OFF     0
`define OBLT_BIT_BUS_WIDE    7
`define OBLT_BIT_LOW_POWER   6
`define OBLT_STAT_DONE       0

// reset values: erased flash reads as all ones; last divider count
`define OBLT_ERASED_BYTE     8'hFF
`define OBLT_DIV_LAST        3'h7

`endif

// file: src/oblt_pkg.sv
// Purpose: types of the option loader
// Assumes: nothing
// Notes:   loader walks a fixed list of flash bytes
package oblt_pkg;
  typedef enum logic [1:0] {
    ST_FETCH,
    ST_WAIT,
    ST_DONE
  } oblt_state_t;
endpackage

// file: src/oblt_byte_reg.sv
// Purpose: byte register loaded by hardware and writable by software
// Assumes: load and write never coincide; load wins if they do
// Notes:   one instance per trim register
`timescale 1ns/10ps
`default_nettype none
module oblt_byte_reg #(
  parameter int        W          = 8,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         loadEn,
  input  wire logic [W-1:0] loadData,
  input  wire logic         writeEn,
  input  wire logic [W-1:0] writeData,
  output logic      [W-1:0] value
);
  logic [W-1:0] value_reg;
  logic [W-1:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (loadEn) begin
      value_next = loadData;
    end else if (writeEn) begin
      value_next = writeData;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule
`default_nettype wire

// file: src/oblt_loader.sv
// Purpose: reset-time option byte and oscillator trim loader with APB access
// Assumes: flash answers each held request with one flashAck pulse
// Notes:   any reset kind restarts the fetch; APB stalls until it ends
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "oblt_map.svh"

module oblt_loader #(
  parameter int AW = 12
) (
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          shortResetReq,
  input  wire logic          stopRecoveryReq,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               flashReq,
  output logic               flashInfoSel,
  output logic      [7:0]    flashAddr,
  input  wire logic [7:0]    flashData,
  input  wire logic          flashAck,
  output logic               cpuRunEnable,
  output logic               motorPinsEnable,
  output logic               highSideOffLevel,
  output logic               lowSideOffLevel,
  output logic               externalBusWideSelect,
  output logic               lowPowerStartup,
  output logic               clockDivEnable,
  output logic               flashAccessWindow,
  output logic      [7:0]    oscillatorTrimOne,
  output logic      [7:0]    oscillatorTrimTwo
);
  import oblt_pkg::*;

  oblt_state_t state_reg;
  oblt_state_t state_next;
  logic [2:0]  idx_reg;
  logic [2:0]  idx_next;
  logic        req_reg;
  logic        req_next;
  logic        info_reg;
  logic        info_next;
  logic [7:0]  addr_reg;
  logic [7:0]  addr_next;
  logic [7:0]  optMotor_reg;
  logic [7:0]  optMotor_next;
  logic [7:0]  optBus_reg;
  logic [7:0]  optBus_next;
  logic [7:0]  factOne_reg;
  logic [7:0]  factOne_next;
  logic [7:0]  factTwo_reg;
  logic [7:0]  factTwo_next;
  logic        done_reg;
  logic        done_next;
  logic        restart;
  logic        trimOneLoad;
  logic        trimTwoLoad;
  logic        lastFetch;

  // any reset kind restarts the load
  assign restart = shortResetReq | stopRecoveryReq;

  assign lastFetch = (idx_reg == `OBLT_FETCH_LAST);

  // fetch sequencer
  always_comb begin
    state_next    = state_reg;
    idx_next      = idx_reg;
    req_next      = req_reg;
    info_next     = info_reg;
    addr_next     = addr_reg;
    optMotor_next = optMotor_reg;
    optBus_next   = optBus_reg;
    factOne_next  = factOne_reg;
    factTwo_next  = factTwo_reg;
    done_next     = done_reg;
    trimOneLoad   = 1'b0;
    trimTwoLoad   = 1'b0;
    if (restart) begin
      state_next = ST_FETCH;
      idx_next   = 3'h0;
      req_next   = 1'b0;
      done_next  = 1'b0;
    end else begin
      case (state_reg)
        ST_FETCH: begin
          req_next   = 1'b1;
          state_next = ST_WAIT;
          case (idx_reg)
            3'h0: begin
              addr_next = `OBLT_FA_OPT_MOTOR;
              info_next = 1'b0;
            end
            3'h1: begin
              addr_next = `OBLT_FA_OPT_RSVD;
              info_next = 1'b0;
            end
            3'h2: begin
              addr_next = `OBLT_FA_OPT_BUS;
              info_next = 1'b0;
            end
            3'h3: begin
              addr_next = `OBLT_FA_INFO_TRIM1;
              info_next = 1'b1;
            end
            default: begin
              addr_next = `OBLT_FA_INFO_TRIM2;
              info_next = 1'b1;
            end
          endcase
        end
        ST_WAIT: begin
          if (flashAck) begin
            req_next = 1'b0;
            // option bytes captured only here, never while running
            case (idx_reg)
              3'h0: begin
                optMotor_next = flashData;
              end
              3'h1: begin
                optMotor_next = optMotor_reg; // reserved byte, all ones expected
              end
              3'h2: begin
                optBus_next = flashData;
              end
              3'h3: begin
                factOne_next = flashData;
                trimOneLoad  = 1'b1;
              end
              default: begin
                factTwo_next = flashData;
                trimTwoLoad  = 1'b1;
              end
            endcase
            if (lastFetch) begin
              state_next = ST_DONE;
              done_next  = 1'b1;
            end else begin
              idx_next   = idx_reg + 3'h1;
              state_next = ST_FETCH;
            end
          end
        end
        ST_DONE: begin
          state_next = ST_DONE;
        end
        default: begin
          state_next = ST_FETCH;
          idx_next   = 3'h0;
          req_next   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= ST_FETCH;
      idx_reg      <= 3'h0;
      req_reg      <= 1'b0;
      info_reg     <= 1'b0;
      addr_reg     <= 8'h00;
      optMotor_reg <= `OBLT_ERASED_BYTE;
      optBus_reg   <= `OBLT_ERASED_BYTE;
      factOne_reg  <= `OBLT_ERASED_BYTE;
      factTwo_reg  <= `OBLT_ERASED_BYTE;
      done_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      idx_reg      <= idx_next;
      req_reg      <= req_next;
      info_reg     <= info_next;
      addr_reg     <= addr_next;
      optMotor_reg <= optMotor_next;
      optBus_reg   <= optBus_next;
      factOne_reg  <= factOne_next;
      factTwo_reg  <= factTwo_next;
      done_reg     <= done_next;
    end
  end

  assign flashReq     = req_reg;
  assign flashInfoSel = info_reg;
  assign flashAddr    = addr_reg;
  assign cpuRunEnable = done_reg;

  // decoded configuration; storage has no bus path
  assign motorPinsEnable       = ~optMotor_reg[`OBLT_BIT_MOTOR_EN];
  assign highSideOffLevel      = optMotor_reg[`OBLT_BIT_HIGH_OFF];
  assign lowSideOffLevel       = optMotor_reg[`OBLT_BIT_LOW_OFF];
  assign externalBusWideSelect = optBus_reg[`OBLT_BIT_BUS_WIDE];
  assign lowPowerStartup       = ~optBus_reg[`OBLT_BIT_LOW_POWER];

  // divide-by-eight clock enable for low power start
  logic [2:0] div_reg;
  logic [2:0] div_next;
  logic       divEn_reg;
  logic       divEn_next;

  always_comb begin
    div_next   = div_reg + 3'h1;
    divEn_next = 1'b1;
    if (lowPowerStartup) begin
      divEn_next = (div_next == `OBLT_DIV_LAST);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg   <= 3'h0;
      divEn_reg <= 1'b0;
    end else begin
      div_reg   <= div_next;
      divEn_reg <= divEn_next;
    end
  end

  assign clockDivEnable    = divEn_reg;
  assign flashAccessWindow = divEn_reg;

  // apb slave
  logic [`OBLT_IDX_BITS-1:0] regIdx;
  logic        access;
  logic        hitTrimOne;
  logic        hitTrimTwo;
  logic        hitInfoOne;
  logic        hitInfoTwo;
  logic        hitStatus;
  logic        mapped;
  logic [31:0] rdValue;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        err_reg;
  logic        err_next;
  logic        rdy_reg;
  logic        rdy_next;
  logic        writeOne;
  logic        writeTwo;

  assign regIdx     = paddr[`OBLT_IDX_BITS+1:2];
  assign hitTrimOne = (regIdx == 8'(`OBLT_IDX_TRIM1));
  assign hitTrimTwo = (regIdx == 8'(`OBLT_IDX_TRIM2));
  assign hitInfoOne = (regIdx == 8'(`OBLT_IDX_INFO1));
  assign hitInfoTwo = (regIdx == 8'(`OBLT_IDX_INFO2));
  assign hitStatus  = (regIdx == 8'(`OBLT_IDX_STATUS));
  assign mapped     = hitTrimOne | hitTrimTwo | hitInfoOne | hitInfoTwo | hitStatus;
  assign access     = psel & penable;

  always_comb begin
    rdValue = 32'h0000_0000;
    if (hitTrimOne) begin
      rdValue[7:0] = oscillatorTrimOne;
    end else if (hitTrimTwo) begin
      rdValue[7:0] = oscillatorTrimTwo;
    end else if (hitInfoOne) begin
      rdValue[7:0] = factOne_reg;
    end else if (hitInfoTwo) begin
      rdValue[7:0] = factTwo_reg;
    end else if (hitStatus) begin
      rdValue[`OBLT_STAT_DONE] = done_reg;
    end
  end

  // answer held back until the load is over
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    rdy_next   = rdy_reg;
    if (restart || (access && rdy_reg)) begin
      rdy_next = 1'b0;
    end else if (psel && done_reg && !rdy_reg) begin
      rdy_next   = 1'b1;
      rdata_next = pwrite ? 32'h0000_0000 : rdValue;
      err_next   = ~mapped;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
      rdy_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
      rdy_reg   <= rdy_next;
    end
  end

  assign pready  = access & rdy_reg;
  assign pslverr = access & rdy_reg & err_reg;
  assign prdata  = rdata_reg;

  // info area and status have no write path
  assign writeOne = access & rdy_reg & pwrite & hitTrimOne;
  assign writeTwo = access & rdy_reg & pwrite & hitTrimTwo;

  oblt_byte_reg #(
    .W         (8),
    .RESET_VAL (`OBLT_ERASED_BYTE)
  ) trimOne (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .loadEn    (trimOneLoad),
    .loadData  (flashData),
    .writeEn   (writeOne),
    .writeData (pwdata[7:0]),
    .value     (oscillatorTrimOne)
  );

  oblt_byte_reg #(
    .W         (8),
    .RESET_VAL (`OBLT_ERASED_BYTE)
  ) trimTwo (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .loadEn    (trimTwoLoad),
    .loadData  (flashData),
    .writeEn   (writeTwo),
    .writeData (pwdata[7:0]),
    .value     (oscillatorTrimTwo)
  );
endmodule
`default_nettype wire

// file: verif/oblt_flash_model.sv
// Purpose: program memory and information area behind the loader
// Assumes: one ack pulse per held request
// Notes:   slow adds wait cycles; idle data toggles
`timescale 1ns/10ps
`default_nettype none
module oblt_flash_model (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       slow,
  input  wire logic [7:0] optMotor,
  input  wire logic [7:0] optBus,
  input  wire logic [7:0] trimOne,
  input  wire logic [7:0] trimTwo,
  input  wire logic       flashReq,
  input  wire logic       flashInfoSel,
  input  wire logic [7:0] flashAddr,
  output logic      [7:0] flashData,
  output logic            flashAck
);
  logic [2:0] waitCnt;
  logic [7:0] rdByte;
  always_comb begin
    case ({flashInfoSel, flashAddr})
      9'h001:  rdByte = optMotor;
      9'h002:  rdByte = 8'hFF;
      9'h003:  rdByte = optBus;
      9'h121:  rdByte = trimOne;
      9'h122:  rdByte = trimTwo;
      default: rdByte = ~flashData;
    endcase
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      waitCnt   <= 3'h0;
      flashAck  <= 1'b0;
      flashData <= 8'h00;
    end else if (flashReq && !flashAck && waitCnt == {slow, 2'h0}) begin
      waitCnt   <= 3'h0;
      flashAck  <= 1'b1;
      flashData <= rdByte;
    end else begin
      waitCnt   <= (flashReq && !flashAck) ? waitCnt + 3'h1 : 3'h0;
      flashAck  <= 1'b0;
      flashData <= ~flashData;
    end
  end
endmodule
`default_nettype wire

// file: verif/oblt_loader_monitor.sv
// Purpose: port checker of the loader
// Assumes: flash and apb follow the hand-over timing
// Notes:   bound to oblt_loader
`timescale 1ns/10ps
`default_nettype none
module oblt_loader_monitor #(
  parameter int AW = 12
) (
  input wire logic          mclk,
  input wire logic          arst_n,
  input wire logic          shortResetReq,
  input wire logic          stopRecoveryReq,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic          flashReq,
  input wire logic          flashInfoSel,
  input wire logic [7:0]    flashAddr,
  input wire logic [7:0]    flashData,
  input wire logic          flashAck,
  input wire logic          cpuRunEnable,
  input wire logic          motorPinsEnable,
  input wire logic          highSideOffLevel,
  input wire logic          lowSideOffLevel,
  input wire logic          externalBusWideSelect,
  input wire logic          lowPowerStartup,
  input wire logic          clockDivEnable,
  input wire logic [7:0]    oscillatorTrimOne,
  input wire logic [7:0]    oscillatorTrimTwo
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [7:0] prevData;
  always_ff @(posedge mclk) begin
    prevData <= flashData;
  end
  sequence s_prog_ack(logic [7:0] a);
    flashReq && flashAck && !flashInfoSel && flashAddr == a;
  endsequence
  sequence s_setup;
    psel && !penable && cpuRunEnable ##1 psel && penable;
  endsequence
  sequence s_div_gap;
    !clockDivEnable [*7] ##1 clockDivEnable;
  endsequence
  chk_motor_bits: assert property (
    s_prog_ack(8'h01) |=> {motorPinsEnable, highSideOffLevel, lowSideOffLevel}
      == {~prevData[2], prevData[1:0]})
    else $error("motor option outputs wrong");
  chk_bus_bits: assert property (
    s_prog_ack(8'h03) |=> {externalBusWideSelect, lowPowerStartup} == {prevData[7], ~prevData[6]})
    else $error("bus option outputs wrong");
  chk_opts_held: assert property (
    !flashAck |=> $stable({motorPinsEnable, highSideOffLevel, lowSideOffLevel,
      externalBusWideSelect, lowPowerStartup}))
    else $error("option output changed outside fetch");
  chk_run_after_load: assert property (
    $rose(cpuRunEnable) |-> $past(flashAck && flashInfoSel && flashAddr == 8'h22))
    else $error("cpu released before load");
  chk_trim_loaded: assert property (
    $rose(cpuRunEnable) |-> oscillatorTrimTwo == $past(flashData))
    else $error("trim not loaded at release");
  chk_apb_gated: assert property (!cpuRunEnable |-> !pready)
    else $error("apb answered during load");
  chk_ready_prompt: assert property (s_setup |-> pready)
    else $error("apb wait state after load");
  chk_trim_write: assert property (
    psel && penable && pready && pwrite && paddr[9:2] == 8'h25
      |=> 32'(oscillatorTrimOne) == ($past(pwdata) & 32'h0000_00FF))
    else $error("trim write lost");
  chk_restart_halt: assert property (
    shortResetReq || stopRecoveryReq |=> !cpuRunEnable [*4])
    else $error("restart did not halt cpu");
  chk_req_hold: assert property (
    flashReq && !flashAck |=> flashReq && $stable(flashAddr) && $stable(flashInfoSel))
    else $error("flash request dropped early");
  chk_div_gap: assert property (
    lowPowerStartup && clockDivEnable && !$past(clockDivEnable) |=> s_div_gap)
    else $error("divide period not eight");
endmodule
bind oblt_loader oblt_loader_monitor #(.AW(AW)) uMon (
  .mclk(mclk), .arst_n(arst_n), .shortResetReq(shortResetReq),
  .stopRecoveryReq(stopRecoveryReq), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .flashReq(flashReq),
  .flashInfoSel(flashInfoSel), .flashAddr(flashAddr), .flashData(flashData),
  .flashAck(flashAck), .cpuRunEnable(cpuRunEnable), .motorPinsEnable(motorPinsEnable),
  .highSideOffLevel(highSideOffLevel), .lowSideOffLevel(lowSideOffLevel),
  .externalBusWideSelect(externalBusWideSelect), .lowPowerStartup(lowPowerStartup),
  .clockDivEnable(clockDivEnable), .oscillatorTrimOne(oscillatorTrimOne),
  .oscillatorTrimTwo(oscillatorTrimTwo));
`default_nettype wire

// file: verif/testbench.sv
// Purpose: self-checking bench of the option and trim loader
// Assumes: apb stalls until the load ends
// Notes:   read result carries pslverr in bit 31
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        mclk, arst_n, shortResetReq, stopRecoveryReq, psel, penable, pwrite, slow;
  logic        pready, pslverr, flashReq, flashInfoSel, flashAck, cpuRunEnable;
  logic        motorPinsEnable, highSideOffLevel, lowSideOffLevel, externalBusWideSelect;
  logic        lowPowerStartup, clockDivEnable, flashAccessWindow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  flashAddr, flashData, optMotor, optBus, trimOne, trimTwo;
  logic [7:0]  oscillatorTrimOne, oscillatorTrimTwo;
  logic [4:0]  opts;
  int          nFail, nCompared, k;
  assign opts = {motorPinsEnable, highSideOffLevel, lowSideOffLevel,
                 externalBusWideSelect, lowPowerStartup};
  oblt_loader #(.AW(12)) uut (
    .mclk(mclk), .arst_n(arst_n), .shortResetReq(shortResetReq),
    .stopRecoveryReq(stopRecoveryReq), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flashReq(flashReq), .flashInfoSel(flashInfoSel), .flashAddr(flashAddr),
    .flashData(flashData), .flashAck(flashAck), .cpuRunEnable(cpuRunEnable),
    .motorPinsEnable(motorPinsEnable), .highSideOffLevel(highSideOffLevel),
    .lowSideOffLevel(lowSideOffLevel), .externalBusWideSelect(externalBusWideSelect),
    .lowPowerStartup(lowPowerStartup), .clockDivEnable(clockDivEnable),
    .flashAccessWindow(flashAccessWindow), .oscillatorTrimOne(oscillatorTrimOne),
    .oscillatorTrimTwo(oscillatorTrimTwo));
  oblt_flash_model uFlash (
    .mclk(mclk), .arst_n(arst_n), .slow(slow), .optMotor(optMotor), .optBus(optBus),
    .trimOne(trimOne), .trimTwo(trimTwo), .flashReq(flashReq),
    .flashInfoSel(flashInfoSel), .flashAddr(flashAddr), .flashData(flashData),
    .flashAck(flashAck));
  always #20 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = {pslverr, prdata[30:0]};
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic restart(input logic s);
    @(posedge mclk);
    shortResetReq   <= s;
    stopRecoveryReq <= !s;
    @(posedge mclk);
    shortResetReq   <= 1'b0;
    stopRecoveryReq <= 1'b0;
  endtask
  task automatic testDone;
    $display("compared %0d, failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    nFail++;
    testDone;
  end
  initial begin
    {mclk, arst_n, shortResetReq, stopRecoveryReq, psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    nFail = 0;
    nCompared = 0;
    slow = 1'b1;
    optMotor = 8'hFA;
    optBus = 8'h7F;
    trimOne = 8'h5A;
    trimTwo = 8'hA5;
    repeat (10) @(posedge mclk);
    chk(32'(oscillatorTrimOne), 32'h0000_00FF);
    arst_n <= 1'b1;
    apb(1'b0, 12'h094, '0);
    chk(r, 32'h0000_005A);
    apb(1'b0, 12'h098, '0);
    chk(r, 32'h0000_00A5);
    chk(32'(opts), 32'h0000_0018);
    apb(1'b1, 12'h084, 32'h0000_0000);
    apb(1'b0, 12'h084, '0);
    chk(r, 32'h0000_005A);
    apb(1'b0, 12'h088, '0);
    chk(r, 32'h0000_00A5);
    apb(1'b1, 12'h094, 32'h0000_0033);
    apb(1'b1, 12'h098, 32'h0000_00CC);
    apb(1'b0, 12'h094, '0);
    chk(r, 32'h0000_0033);
    chk(32'(oscillatorTrimTwo), 32'h0000_00CC);
    apb(1'b0, 12'h0FC, '0);
    chk(r, 32'h8000_0000);
    apb(1'b0, 12'h004, '0);
    chk(r, 32'h8000_0000);
    apb(1'b0, 12'h0C0, '0);
    chk(r, 32'h0000_0001);
    optMotor <= 8'hFD;
    optBus <= 8'hFF;
    trimOne <= 8'h11;
    slow <= 1'b0;
    apb(1'b1, 12'h004, 32'h0000_0000);
    repeat (20) @(posedge mclk);
    chk(32'(opts), 32'h0000_0018);
    restart(1'b1);
    apb(1'b0, 12'h094, '0);
    chk(r, 32'h0000_0011);
    chk(32'(opts), 32'h0000_0006);
    trimTwo <= 8'h77;
    restart(1'b0);
    apb(1'b0, 12'h098, '0);
    chk(r, 32'h0000_0077);
    optBus <= 8'h3F;
    arst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, 12'h094, '0);
    chk(r, 32'h0000_0011);
    chk(32'(opts), 32'h0000_0005);
    k = 0;
    repeat (16) begin
      @(posedge mclk);
      k = k + (clockDivEnable === 1'b1) + 16 * (flashAccessWindow !== clockDivEnable);
    end
    chk(32'(k), 32'h0000_0002);
    testDone;
  end
endmodule
`default_nettype wire
